// *** core/cnid_core.sv ***
// Node identifier assignment logic of a CAN connection box
// How it works
// - With nothing else assigned, the node identifier is 110.
// - Switch at zero allows identifier change over the bus.
// - Switch at 1 to 9 gives identifier 110 plus switch value.
// - Assignment frame is 0x7F2, bytes 0-3 zero, new identifier bytes 4-5.
// - Assignment frame with any non-zero byte among bytes 0-3 is discarded.
// - Assignment frame is discarded while the switch is not zero.
// - Valid frame enters assignment mode, display blinks pending identifier.
// - Button press in assignment mode confirms pending identifier.
// - Mode held until confirmation, reset-communication or reset-node command.
// - No normal bus communication while in assignment mode.
// - Reset-communication leaves the mode, all other state unchanged.
// - Confirmed identifier used only after power cycle or reset-node.
// - With remote power-up enabled, switch-on command over CAN boots device.
`timescale 1ns/1ps
module cnid_core
  import cnid_pkg::*;
#(
  parameter int BLINK_COUNT = BLINK_CYCLES
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [31:0]       reg_rdata_out,
  // Received frames from the CAN controller
  input  wire logic              rx_valid_in,
  input  wire logic [10:0]       rx_cob_id_in,
  input  wire logic [63:0]       rx_data_in,
  // Front panel
  input  wire logic [3:0]        sw_pin_in,
  input  wire logic              set_button_in,
  output logic      [ID_W-1:0]   display_id_out,
  output logic                   display_on_out,
  // Non-volatile identifier store
  input  wire logic              nv_valid_in,
  input  wire logic [ID_W-1:0]   nv_id_in,
  output logic                   nv_write_out,
  output logic      [ID_W-1:0]   nv_id_out,
  // Node state towards the rest of the box
  output logic      [ID_W-1:0]   node_id_out,
  output logic                   comm_enable_out,
  output logic                   power_on_out
);
  cnid_state_t     state_reg;
  cnid_state_t     state_next;
  logic [ID_W-1:0] active_id_reg;
  logic [ID_W-1:0] pending_id_reg;
  logic [ID_W-1:0] confirmed_id_reg;
  logic            confirmed_reg;
  logic            power_on_reg;
  logic [1:0]      ctrl_reg;
  logic [31:0]     rdata_reg;
  logic            nv_write_reg;
  logic [ID_W-1:0] nv_id_reg;
  logic            btn_prev_reg;
  logic [31:0]     blink_cnt_reg;
  logic            blink_reg;
  logic [2:0]      boot_cnt_reg;
  logic [3:0]      sw_level;
  logic            btn_level;

  // Switch and button come from the panel, so they cross into this clock
  cnid_sync #(.WIDTH(4)) u_sw_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .pin_in    (sw_pin_in),
    .level_out (sw_level)
  );
  cnid_sync #(.WIDTH(1)) u_btn_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .pin_in    (set_button_in),
    .level_out (btn_level)
  );

  // Frame decode
  wire        in_mode     = (state_reg == CNID_ASSIGN);
  wire        in_run      = (state_reg == CNID_RUN);
  wire        sw_zero     = (sw_level == 4'h0);
  wire        sw_in_range = !sw_zero && (sw_level <= SW_MAX);
  wire [31:0] lead_bytes  = rx_data_in[ZERO_BYTES*8-1:0];
  wire [ID_W-1:0] frame_id = {rx_data_in[ID_HI_BYTE*8 +: 8], rx_data_in[ID_LO_BYTE*8 +: 8]};
  wire        is_assign   = rx_valid_in && (rx_cob_id_in == ASSIGN_COB_ID);
  wire        is_nmt      = rx_valid_in && (rx_cob_id_in == NMT_COB_ID);
  wire [7:0]  nmt_cmd     = rx_data_in[7:0];
  wire [7:0]  nmt_node    = rx_data_in[15:8];
  wire        nmt_for_us  = (nmt_node == NMT_ALL_NODES) || (nmt_node == active_id_reg[7:0]);
  wire        nmt_hit     = is_nmt && nmt_for_us && (state_reg != CNID_BOOT);
  wire        reset_comm  = nmt_hit && (nmt_cmd == NMT_RESET_COMM);
  wire        reset_node  = nmt_hit && (nmt_cmd == NMT_RESET_NODE);
  wire        switch_on   = nmt_hit && in_run && (nmt_cmd == NMT_START);
  wire        accept      = is_assign && in_run && (lead_bytes == 32'h0) && sw_zero;
  wire        btn_press   = btn_level && !btn_prev_reg;
  wire        confirm     = in_mode && btn_press;
  wire        load_id     = (state_reg == CNID_BOOT) || reset_node;
  // Last boot cycle; the switch level has settled by then
  wire        boot_done   = (boot_cnt_reg == 3'(BOOT_CYCLES - 1));

  // Identifier chosen at boot or reset-node
  // switch value first, then confirmed, then stored, else factory default
  wire [ID_W-1:0] load_value =
      sw_in_range   ? (DEFAULT_ID + {12'h000, sw_level}) :
      confirmed_reg ? confirmed_id_reg :
      nv_valid_in   ? nv_id_in : DEFAULT_ID;

  // Mode sequencing
  // enter on valid frame
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CNID_BOOT: begin
        if (boot_done) begin
          state_next = CNID_RUN;
        end
      end
      CNID_RUN: begin
        if (accept) begin
          state_next = CNID_ASSIGN;
        end
      end
      CNID_ASSIGN: begin
        if (confirm || reset_comm || reset_node) begin
          state_next = CNID_RUN;
        end
      end
      default: begin
        state_next = CNID_BOOT;
      end
    endcase
  end

  // State and identifier registers; boot value is caught after reset release
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg     <= CNID_BOOT;
      active_id_reg <= DEFAULT_ID;
      btn_prev_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      btn_prev_reg  <= btn_level;
      if (load_id) begin
        active_id_reg <= load_value;
      end
    end
  end

  // boot waits for the switch
  // Loading at the first edge would miss a switch set before power-up
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      boot_cnt_reg <= 3'h0;
    end else if (state_reg == CNID_BOOT) begin
      boot_cnt_reg <= boot_cnt_reg + 3'h1;
    end
  end

  // Pending identifier captured from the accepted frame
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_id_reg <= DEFAULT_ID;
    end else if (accept) begin
      pending_id_reg <= frame_id;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      confirmed_id_reg <= DEFAULT_ID;
      confirmed_reg    <= 1'b0;
      nv_write_reg     <= 1'b0;
      nv_id_reg        <= DEFAULT_ID;
    end else begin
      nv_write_reg <= confirm;
      if (confirm) begin
        confirmed_id_reg <= pending_id_reg;
        confirmed_reg    <= 1'b1;
        nv_id_reg        <= pending_id_reg;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_on_reg <= 1'b0;
    end else if ((switch_on && ctrl_reg[CTRL_REMOTE_EN]) || ctrl_reg[CTRL_LOCAL_ON]) begin
      power_on_reg <= 1'b1;
    end
  end

  // Blink timer; held clear outside the mode so the pending value shows at once
  wire blink_wrap = (blink_cnt_reg == 32'(BLINK_COUNT - 1));
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= 1'b1;
    end else if (!in_mode || blink_wrap) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= in_mode ? !blink_reg : 1'b1;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // Register write
  wire wr_ctrl = reg_wr_in && (reg_addr_in == CTRL_ADDR);
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata_in[1:0];
    end
  end

  // Register read decode; unmapped addresses read zero
  wire [31:0] status_word = {24'h0, sw_level, !in_run && !in_mode, confirmed_reg,
                             power_on_reg, in_mode};
  wire [31:0] rd_mux =
      (reg_addr_in == CTRL_ADDR)    ? {30'h0, ctrl_reg} :
      (reg_addr_in == STATUS_ADDR)  ? {status_word[31:4], status_word[3] ^ 1'b1,
                                       status_word[2:0]} :
      (reg_addr_in == ACTIVE_ADDR)  ? {16'h0, active_id_reg} :
      (reg_addr_in == PENDING_ADDR) ? {16'h0, pending_id_reg} :
      (reg_addr_in == CONFIRM_ADDR) ? {16'h0, confirmed_id_reg} : 32'h0;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= reg_rd_in ? rd_mux : 32'h0;
    end
  end

  // Outputs
  assign reg_rdata_out   = rdata_reg;
  assign node_id_out     = active_id_reg;
  assign display_id_out  = in_mode ? pending_id_reg : active_id_reg;
  assign display_on_out  = blink_reg;
  assign comm_enable_out = in_run && power_on_reg;
  assign power_on_out    = power_on_reg;
  assign nv_write_out    = nv_write_reg;
  assign nv_id_out       = nv_id_reg;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_default_id;
    load_id && sw_zero && !confirmed_reg && !nv_valid_in |=> active_id_reg == DEFAULT_ID;
  endproperty
  a_default_id: assert property (p_default_id) else $error("default id not used");

  property p_switch_id;
    load_id && sw_in_range |=> active_id_reg == DEFAULT_ID + {12'h000, $past(sw_level)};
  endproperty
  a_switch_id: assert property (p_switch_id) else $error("switch id wrong");

  property p_discard_bytes;
    is_assign && (lead_bytes != 32'h0) |=> !$rose(in_mode) && $stable(pending_id_reg);
  endproperty
  a_discard_bytes: assert property (p_discard_bytes) else $error("bad frame taken");

  property p_discard_sw;
    is_assign && !sw_zero |=> $stable(pending_id_reg) && !($rose(in_mode));
  endproperty
  a_discard_sw: assert property (p_discard_sw) else $error("frame taken off zero");

  property p_enter;
    accept |=> in_mode && pending_id_reg == $past(frame_id) && display_id_out == pending_id_reg;
  endproperty
  a_enter: assert property (p_enter) else $error("mode not entered");

  property p_confirm;
    confirm |=> !in_mode && confirmed_id_reg == $past(pending_id_reg)
                && active_id_reg == $past(active_id_reg);
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm wrong");

  property p_hold;
    in_mode && !confirm && !reset_comm && !reset_node |=> in_mode;
  endproperty
  a_hold: assert property (p_hold) else $error("mode left early");

  property p_quiet;
    in_mode |-> !comm_enable_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("comm in mode");

  property p_reset_comm;
    in_mode && reset_comm |=> !in_mode && $stable(active_id_reg) && $stable(power_on_reg);
  endproperty
  a_reset_comm: assert property (p_reset_comm) else $error("reset comm wrong");

  property p_power;
    switch_on && ctrl_reg[CTRL_REMOTE_EN] |=> power_on_out ##1 power_on_out;
  endproperty
  a_power: assert property (p_power) else $error("no remote power-up");

  property p_nv;
    confirm |=> nv_write_out && nv_id_out == $past(pending_id_reg) ##1 !nv_write_out;
  endproperty
  a_nv: assert property (p_nv) else $error("nv write missing");

  property p_accept;
    is_assign && in_run && sw_zero && (lead_bytes == 32'h0) |=> in_mode;
  endproperty
  a_accept: assert property (p_accept) else $error("good frame dropped");

  property p_layout;
    accept |=> pending_id_reg == {$past(rx_data_in[ID_HI_BYTE*8 +: 8]),
                                  $past(rx_data_in[ID_LO_BYTE*8 +: 8])};
  endproperty
  a_layout: assert property (p_layout) else $error("id bytes misplaced");

  property p_apply;
    !load_id |=> $stable(node_id_out);
  endproperty
  a_apply: assert property (p_apply) else $error("id changed without reload");

  c_boot_wait: cover property (boot_done && sw_in_range);

  c_assign: cover property (accept ##[1:20] confirm);
  c_release: cover property (accept ##[1:20] reset_comm);
  c_apply: cover property (confirm ##[1:40] reset_node);
  c_boot: cover property (switch_on && ctrl_reg[CTRL_REMOTE_EN]);
endmodule : cnid_core

// *** core/cnid_pkg.sv ***
// Shared constants for the CAN node identifier assignment block
package cnid_pkg;
  // Identifier widths and the factory identifier
  localparam int          ID_W           = 16;
  localparam logic [15:0] DEFAULT_ID     = 16'h006e;
  localparam logic [3:0]  SW_MAX         = 4'h9;
  // Assignment frame and network-management frame layout
  localparam logic [10:0] ASSIGN_COB_ID  = 11'h7f2;
  localparam logic [10:0] NMT_COB_ID     = 11'h000;
  localparam logic [7:0]  NMT_START      = 8'h01;
  localparam logic [7:0]  NMT_RESET_NODE = 8'h81;
  localparam logic [7:0]  NMT_RESET_COMM = 8'h82;
  localparam logic [7:0]  NMT_ALL_NODES  = 8'h00;
  localparam int          ZERO_BYTES     = 4;
  localparam int          ID_LO_BYTE     = 4;
  localparam int          ID_HI_BYTE     = 5;
  // Register bus map, byte addresses
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  CTRL_ADDR      = 8'h00;
  localparam logic [7:0]  STATUS_ADDR    = 8'h04;
  localparam logic [7:0]  ACTIVE_ADDR    = 8'h08;
  localparam logic [7:0]  PENDING_ADDR   = 8'h0c;
  localparam logic [7:0]  CONFIRM_ADDR   = 8'h10;
  // Control register fields and reset value
  localparam int          CTRL_REMOTE_EN = 0;
  localparam int          CTRL_LOCAL_ON  = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  // Status register fields
  localparam int          ST_MODE        = 0;
  localparam int          ST_POWER       = 1;
  localparam int          ST_CONFIRMED   = 2;
  localparam int          ST_LOADED      = 3;
  localparam int          ST_SW_LSB      = 4;
  // Display blink timing
  localparam int          CLK_HZ         = 125_000_000;
  localparam int          BLINK_HALF_MS  = 500;
  localparam int          BLINK_CYCLES   = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int          SYNC_STAGES    = 3;
  // Boot wait spans the switch synchroniser and its agreement stage
  localparam int          BOOT_CYCLES    = SYNC_STAGES + 2;
  // Block states
  typedef enum logic [1:0] {CNID_BOOT, CNID_RUN, CNID_ASSIGN} cnid_state_t;
endpackage : cnid_pkg

// *** core/cnid_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cnid_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // Accept a new level only when stages two and three agree
  assign level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
  assign level_out  = level_reg;

  // First stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end
endmodule : cnid_sync

// *** testbench/can_node_id_assignment_tb.sv ***
// Self-checking bench for the node identifier block
`timescale 1ns/1ps
module can_node_id_assignment_tb;
  import cnid_pkg::*;
  logic              clk_in       = 1'b0;
  logic              resetn_in    = 1'b0;
  logic [ADDR_W-1:0] reg_addr_in  = '0;
  logic [31:0]       reg_wdata_in = '0;
  logic              reg_wr_in    = 1'b0;
  logic              reg_rd_in    = 1'b0;
  logic [3:0]        sw_pin_in    = 4'h0;
  logic              set_btn      = 1'b0;
  logic              nv_valid     = 1'b0;
  logic [15:0]       nv_id        = 16'h0000;
  logic [31:0]       rdata;
  logic [15:0]       disp_id, nv_out, node_id;
  logic              disp_on, nv_wr, comm_en, power_on, rx_valid;
  logic [10:0]       rx_cob;
  logic [63:0]       rx_data;
  int                error_cnt    = 0;
  int                check_count  = 0;

  always #4 clk_in = ~clk_in;

  cnid_master_model master_u (.clk_in(clk_in), .rx_valid_out(rx_valid),
    .rx_cob_id_out(rx_cob), .rx_data_out(rx_data));

  // Short blink period keeps the run small
  cnid_core #(.BLINK_COUNT(4)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .rx_valid_in(rx_valid),
    .rx_cob_id_in(rx_cob), .rx_data_in(rx_data), .sw_pin_in(sw_pin_in),
    .set_button_in(set_btn), .display_id_out(disp_id), .display_on_out(disp_on),
    .nv_valid_in(nv_valid), .nv_id_in(nv_id), .nv_write_out(nv_wr), .nv_id_out(nv_out),
    .node_id_out(node_id), .comm_enable_out(comm_en), .power_on_out(power_on));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    #1 d = rdata;
  endtask : reg_read

  task automatic reset_node(input logic [15:0] exp);
    master_u.send_nmt(NMT_RESET_NODE);
    cyc(2);
    check("node id", {16'h0, exp}, {16'h0, node_id});
  endtask : reset_node

  task automatic t_default();
    logic [31:0] d;
    check("node id", 32'h0000_006e, {16'h0, node_id});
    reg_read(ACTIVE_ADDR, d);
    check("active reg", 32'h0000_006e, d);
    reg_read(8'hfc, d);
    check("unmapped", 32'h0000_0000, d);
    nv_valid <= 1'b1;
    nv_id    <= 16'h0033;
    reset_node(16'h0033);
    nv_valid <= 1'b0;
    reset_node(DEFAULT_ID);
  endtask : t_default

  task automatic t_power();
    logic [31:0] d;
    reg_write(CTRL_ADDR, 32'h0);
    master_u.send_nmt(NMT_START);
    cyc(2);
    check("power off", 32'h0, {31'h0, power_on});
    reg_write(CTRL_ADDR, 32'h1);
    reg_read(CTRL_ADDR, d);
    check("ctrl", 32'h1, d);
    master_u.send_nmt(NMT_START);
    cyc(2);
    check("power on", 32'h1, {31'h0, power_on});
    check("comm", 32'h1, {31'h0, comm_en});
  endtask : t_power

  task automatic t_switch();
    logic [31:0] d;
    for (int s = 1; s <= 9; s++) begin
      sw_pin_in <= s[3:0];
      cyc(8);
      reset_node(DEFAULT_ID + 16'(s));
      master_u.send_assign(16'h0012, 8'h00);
      cyc(2);
      reg_read(STATUS_ADDR, d);
      check("mode", 32'h0, {31'h0, d[ST_MODE]});
    end
    sw_pin_in <= 4'h0;
    cyc(8);
    reset_node(DEFAULT_ID);
  endtask : t_switch

  task automatic t_assign();
    logic prev;
    int   flips;
    flips = 0;
    master_u.send_assign(16'h0012, 8'h01);
    cyc(2);
    check("comm", 32'h1, {31'h0, comm_en});
    master_u.send_assign(16'h0012, 8'h00);
    cyc(1);
    check("comm", 32'h0, {31'h0, comm_en});
    check("display", 32'h12, {16'h0, disp_id});
    for (int i = 0; i < 12; i++) begin
      prev = disp_on;
      cyc(1);
      if (prev !== disp_on) flips++;
    end
    // Four-cycle blink half-period toggles on every fourth edge of the twelve
    check("blink flips", 32'h3, flips);
    master_u.release_all();
    cyc(2);
    check("comm", 32'h1, {31'h0, comm_en});
    check("node id", 32'h6e, {16'h0, node_id});
    check("power on", 32'h1, {31'h0, power_on});
  endtask : t_assign

  task automatic t_confirm();
    logic [31:0] d;
    int          hits;
    hits = 0;
    master_u.send_assign(16'h0012, 8'h00);
    @(posedge clk_in);
    set_btn <= 1'b1;
    // Button passes a synchroniser, so allow a dozen cycles
    for (int i = 0; i < 12; i++) begin
      cyc(1);
      if (nv_wr === 1'b1) begin
        hits++;
        d = {16'h0, nv_out};
      end
    end
    set_btn <= 1'b0;
    check("nv pulses", 32'h1, hits);
    check("nv id", 32'h12, d);
    check("comm", 32'h1, {31'h0, comm_en});
    check("node id", 32'h6e, {16'h0, node_id});
    reg_read(CONFIRM_ADDR, d);
    check("confirmed", 32'h12, d);
    reset_node(16'h0012);
  endtask : t_confirm

  // Power cycle: the stored id, then the switch, must be taken at boot
  task automatic t_cycle();
    nv_valid  <= 1'b1;
    nv_id     <= 16'h0012;
    resetn_in <= 1'b0;
    cyc(2);
    resetn_in <= 1'b1;
    cyc(8);
    check("node id", 32'h0000_0012, {16'h0, node_id});
    sw_pin_in <= 4'h3;
    resetn_in <= 1'b0;
    cyc(2);
    resetn_in <= 1'b1;
    cyc(8);
    check("node id", {16'h0, DEFAULT_ID + 16'h0003}, {16'h0, node_id});
    sw_pin_in <= 4'h0;
  endtask : t_cycle

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    cyc(4);
    t_default();
    t_power();
    t_switch();
    t_assign();
    t_confirm();
    t_cycle();
    give_verdict();
  end
endmodule : can_node_id_assignment_tb

// *** testbench/cnid_master_model.sv ***
// Bus master model that sends frames to the node identifier block
`timescale 1ns/1ps
module cnid_master_model
  import cnid_pkg::*;
(
  input  wire logic        clk_in,
  output logic             rx_valid_out,
  output logic [10:0]      rx_cob_id_out,
  output logic [63:0]      rx_data_out
);
  // Lines carry junk between frames, never the last frame
  initial begin
    rx_valid_out  = 1'b0;
    rx_cob_id_out = 11'h555;
    rx_data_out   = 64'ha5a5_a5a5_a5a5_a5a5;
  end

  // One frame, taken at the second edge
  task automatic send(input logic [10:0] cob, input logic [63:0] data);
    @(posedge clk_in);
    rx_valid_out  <= 1'b1;
    rx_cob_id_out <= cob;
    rx_data_out   <= data;
    @(posedge clk_in);
    rx_valid_out  <= 1'b0;
    rx_cob_id_out <= ~cob;
    rx_data_out   <= ~data;
  endtask : send

  // id in bytes four and five
  task automatic send_assign(input logic [15:0] id, input logic [7:0] junk);
    send(ASSIGN_COB_ID, {16'h0000, id, 8'h00, junk, 16'h0000});
  endtask : send_assign

  // Network-management command to all nodes
  task automatic send_nmt(input logic [7:0] cmd);
    send(NMT_COB_ID, {48'h0, NMT_ALL_NODES, cmd});
  endtask : send_nmt

  task automatic release_all();
    send_nmt(NMT_RESET_COMM);
  endtask : release_all
endmodule : cnid_master_model
